// >>> rtl/sat_weight_prc_test_regs.sv
// Purpose: weight generator, prime channel and test substitution registers
// Assumes: byte register port fed by the serial slave decoder
// Notes: samples pass a FIFO, then a registered substitution stage
//
// Notes on behaviour
// [R1] bad frame sync plus gate zeroes weights
// [R2] cycle slip plus gate zeroes weights
// [R3] queue and calc enables; all gates reset set
// [R4] read-only running bit per weight generator
// [R5] prime channel runs when enabled; source select
// [R6] nine-bit channel number, legal 1 to 258
// [R7] select bit swaps decoded data for test
// [R8] five select bits, reset to zero
// [R9] 8-bit terrestrial real/imag test values
// [R10] 4-bit satellite real/imag test values
// [R11] 4-bit weight test value per satellite
// [R12] controls apply per whole symbol, glitch free
`timescale 1ns/1ps

module sat_weight_prc_test_regs
    import sat_weight_prc_pkg::*;
#(
    parameter int unsigned QUEUE_DEPTH = `QUEUE_DEPTH_DEFAULT
) (
    input  wire logic    clk_in,
    input  wire logic    rst_n_in,
    input  wire logic    reg_wr_in,
    input  wire logic    reg_rd_in,
    input  wire logic [9:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic [7:0]   reg_rdata_out,
    output logic         reg_rvalid_out,
    input  wire logic    sample_valid_in,
    input  wire sample_t sample_in,
    output logic         sample_ready_out,
    output logic         out_valid_out,
    output sample_t      out_sample_out,
    input  wire logic    out_ready_in,
    input  wire logic    sat_one_weight_running_in,
    input  wire logic    sat_two_weight_running_in,
    output logic         sat_one_weight_queue_on_out,
    output logic         sat_one_weight_calc_on_out,
    output logic         sat_two_weight_queue_on_out,
    output logic         sat_two_weight_calc_on_out,
    output logic         prime_run_out,
    output logic [1:0]   prime_source_out,
    output logic [8:0]   prime_number_out
);

    ////////////////////////////////////////////////////////////////////////////
    // reset release
    logic [1:0]  rst_sync_q;
    logic        rst_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_q = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // sample queue
    logic        q_valid;
    sample_t     q_data;
    logic        take;

    sample_queue #(
        .WIDTH ($bits(sample_t)),
        .DEPTH (QUEUE_DEPTH)
    ) u_queue (
        .clk_in        (clk_in),
        .rst_n_in      (rst_q),
        .in_valid_in   (sample_valid_in),
        .in_data_in    (sample_in),
        .in_ready_out  (sample_ready_out),
        .out_valid_out (q_valid),
        .out_data_out  (q_data),
        .out_ready_in  (take)
    );

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    bank_state_t q;
    bank_state_t n;

    function automatic bank_state_t reset_state();
        reset_state            = '0;
        reset_state.gen_enable = `RST_WEIGHT_GEN_ENABLE; // [R3]
        reset_state.sub_sel    = 5'(`RST_ZERO_BYTE); // [R8]
    endfunction

    function automatic logic [3:0] pick_weight(
        input logic [3:0] gen,
        input logic       bad,
        input logic       slip,
        input logic       bad_gate,
        input logic       slip_gate,
        input logic       sub,
        input logic [3:0] test
    );
        if (sub) begin
            pick_weight = test; // [R11]
        end else if ((bad && bad_gate) || (slip && slip_gate)) begin
            pick_weight = `ZERO_NIBBLE; // [R1] [R2]
        end else begin
            pick_weight = gen;
        end
    endfunction

    function automatic logic [3:0] pick_nibble(
        input logic       sub,
        input logic [3:0] test,
        input logic [3:0] orig
    );
        pick_nibble = sub ? test : orig; // [R7] [R10]
    endfunction

    function automatic logic num_ok(input logic [8:0] num);
        num_ok = (num >= `PRIME_NUM_MIN) && (num <= `PRIME_NUM_MAX);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        n           = q;
        n.rvalid    = 1'b0;
        n.gen_state = {sat_two_weight_running_in, sat_one_weight_running_in}; // [R4]
        take        = q_valid && (!q.out_valid || out_ready_in);

        if (reg_wr_in) begin
            unique case (reg_addr_in)
                `OFS_WEIGHT_GEN_ENABLE: n.gen_enable = reg_wdata_in; // [R3]
                `OFS_PRIME_CTRL: begin
                    n.prime_en = reg_wdata_in[`BIT_PRIME_ENABLE]; // [R5]
                    if (reg_wdata_in[`BIT_PRIME_SRC_HI:`BIT_PRIME_SRC_LO]
                        != `CODE_SRC_RESERVED) begin
                        n.prime_src = prime_source_t'(
                            reg_wdata_in[`BIT_PRIME_SRC_HI:`BIT_PRIME_SRC_LO]); // [R5]
                    end
                end
                `OFS_PRIME_NUM_LOW:  n.prime_num[7:0] = reg_wdata_in; // [R6]
                `OFS_PRIME_NUM_HIGH: n.prime_num[`BIT_PRIME_NUM_TOP] = reg_wdata_in[0]; // [R6]
                `OFS_SUB_SELECT:     n.sub_sel = reg_wdata_in[4:0]; // [R8]
                `OFS_TERR_TEST_REAL: n.terr_re = reg_wdata_in; // [R9]
                `OFS_TERR_TEST_IMAG: n.terr_im = reg_wdata_in; // [R9]
                `OFS_SAT_ONE_TEST_REAL: n.s1_re = reg_wdata_in[3:0]; // [R10]
                `OFS_SAT_ONE_TEST_IMAG: n.s1_im = reg_wdata_in[3:0]; // [R10]
                `OFS_SAT_TWO_TEST_REAL: n.s2_re = reg_wdata_in[3:0]; // [R10]
                `OFS_SAT_TWO_TEST_IMAG: n.s2_im = reg_wdata_in[3:0]; // [R10]
                `OFS_SAT_ONE_WEIGHT: n.w1 = reg_wdata_in[3:0]; // [R11]
                `OFS_SAT_TWO_WEIGHT: n.w2 = reg_wdata_in[3:0]; // [R11]
                default: ;
            endcase
        end

        if (reg_rd_in) begin
            n.rvalid = 1'b1;
            unique case (reg_addr_in)
                `OFS_WEIGHT_GEN_ENABLE: n.rdata = q.gen_enable;
                `OFS_WEIGHT_GEN_STATE:  n.rdata = {6'h00, q.gen_state}; // [R4]
                `OFS_PRIME_CTRL:        n.rdata = {5'h00, q.prime_src, q.prime_en};
                `OFS_PRIME_NUM_LOW:     n.rdata = q.prime_num[7:0];
                `OFS_PRIME_NUM_HIGH:    n.rdata = {7'h00, q.prime_num[`BIT_PRIME_NUM_TOP]};
                `OFS_SUB_SELECT:        n.rdata = {3'h0, q.sub_sel};
                `OFS_TERR_TEST_REAL:    n.rdata = q.terr_re;
                `OFS_TERR_TEST_IMAG:    n.rdata = q.terr_im;
                `OFS_SAT_ONE_TEST_REAL: n.rdata = {4'h0, q.s1_re};
                `OFS_SAT_ONE_TEST_IMAG: n.rdata = {4'h0, q.s1_im};
                `OFS_SAT_TWO_TEST_REAL: n.rdata = {4'h0, q.s2_re};
                `OFS_SAT_TWO_TEST_IMAG: n.rdata = {4'h0, q.s2_im};
                `OFS_SAT_ONE_WEIGHT:    n.rdata = {4'h0, q.w1};
                `OFS_SAT_TWO_WEIGHT:    n.rdata = {4'h0, q.w2};
                default:                n.rdata = `RST_ZERO_BYTE;
            endcase
        end

        // whole symbol is muxed in one edge from settled controls
        if (take) begin // [R12]
            n.out_valid = 1'b1;
            n.out       = q_data;
            n.out.terr_re = q.sub_sel[`BIT_SUB_TERR_DATA] ? q.terr_re : q_data.terr_re; // [R9]
            n.out.terr_im = q.sub_sel[`BIT_SUB_TERR_DATA] ? q.terr_im : q_data.terr_im; // [R9]
            n.out.s1_re = pick_nibble(q.sub_sel[`BIT_SUB_SAT_ONE_DATA], q.s1_re, q_data.s1_re);
            n.out.s1_im = pick_nibble(q.sub_sel[`BIT_SUB_SAT_ONE_DATA], q.s1_im, q_data.s1_im);
            n.out.s2_re = pick_nibble(q.sub_sel[`BIT_SUB_SAT_TWO_DATA], q.s2_re, q_data.s2_re);
            n.out.s2_im = pick_nibble(q.sub_sel[`BIT_SUB_SAT_TWO_DATA], q.s2_im, q_data.s2_im);
            n.out.w1 = pick_weight(q_data.w1, q_data.bad1, q_data.slip1,
                q.gen_enable[`BIT_SAT_ONE_BAD_SYNC], q.gen_enable[`BIT_SAT_ONE_SLIP],
                q.sub_sel[`BIT_SUB_SAT_ONE_WEIGHT], q.w1);
            n.out.w2 = pick_weight(q_data.w2, q_data.bad2, q_data.slip2,
                q.gen_enable[`BIT_SAT_TWO_BAD_SYNC], q.gen_enable[`BIT_SAT_TWO_SLIP],
                q.sub_sel[`BIT_SUB_SAT_TWO_WEIGHT], q.w2);
        end else if (out_ready_in) begin
            n.out_valid = 1'b0;
        end

        n.prime_run = n.prime_en && (n.prime_src != SRC_RESERVED)
                      && num_ok(n.prime_num); // [R5] [R6]
    end

    always_ff @(posedge clk_in or negedge rst_q) begin
        if (!rst_q) begin
            q <= reset_state();
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata_out               = q.rdata;
    assign reg_rvalid_out              = q.rvalid;
    assign out_valid_out               = q.out_valid;
    assign out_sample_out              = q.out;
    assign sat_one_weight_queue_on_out = q.gen_enable[`BIT_SAT_ONE_QUEUE]; // [R3]
    assign sat_one_weight_calc_on_out  = q.gen_enable[`BIT_SAT_ONE_CALC]; // [R3]
    assign sat_two_weight_queue_on_out = q.gen_enable[`BIT_SAT_TWO_QUEUE]; // [R3]
    assign sat_two_weight_calc_on_out  = q.gen_enable[`BIT_SAT_TWO_CALC]; // [R3]
    assign prime_run_out               = q.prime_run;
    assign prime_source_out            = q.prime_src;
    assign prime_number_out            = q.prime_num;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_q);

    sequence s_take;
        take;
    endsequence

    sequence s_sat_one_zero;
        take && !q.sub_sel[`BIT_SUB_SAT_ONE_WEIGHT];
    endsequence

    chk_bad_sync_zero: assert property ( // [R1]
        s_sat_one_zero and (q_data.bad1 && q.gen_enable[`BIT_SAT_ONE_BAD_SYNC])
        |=> (out_sample_out.w1 == `ZERO_NIBBLE))
        else $error("sat one weight not zeroed on bad sync");

    chk_slip_zero: assert property ( // [R2]
        s_take and (!q.sub_sel[`BIT_SUB_SAT_TWO_WEIGHT] && q_data.slip2
        && q.gen_enable[`BIT_SAT_TWO_SLIP]) |=> (out_sample_out.w2 == `ZERO_NIBBLE))
        else $error("sat two weight not zeroed on slip");

    chk_gate_write: assert property ( // [R3]
        (reg_wr_in && reg_addr_in == `OFS_WEIGHT_GEN_ENABLE)
        |=> (sat_two_weight_queue_on_out == $past(reg_wdata_in[`BIT_SAT_TWO_QUEUE]))
            && (sat_one_weight_calc_on_out == $past(reg_wdata_in[`BIT_SAT_ONE_CALC])))
        else $error("weight gate outputs not following write");

    chk_state_read: assert property ( // [R4]
        (reg_rd_in && reg_addr_in == `OFS_WEIGHT_GEN_STATE) |=> reg_rvalid_out
        && (reg_rdata_out[1:0] == $past({sat_two_weight_running_in,
                                         sat_one_weight_running_in}, 2)))
        else $error("weight state readback wrong");

    chk_prime_run: assert property ( // [R5]
        prime_run_out |-> q.prime_en && (prime_source_out != `CODE_SRC_RESERVED))
        else $error("prime channel running while disabled");

    chk_prime_range: assert property ( // [R6]
        prime_run_out |-> (prime_number_out >= `PRIME_NUM_MIN)
                          && (prime_number_out <= `PRIME_NUM_MAX))
        else $error("prime channel running out of range");

    chk_data_sub: assert property ( // [R10]
        s_take and q.sub_sel[`BIT_SUB_SAT_ONE_DATA]
        |=> (out_sample_out.s1_re == $past(q.s1_re)) && out_valid_out)
        else $error("sat one test data not substituted");

    chk_data_pass: assert property ( // [R7]
        s_take and !q.sub_sel[`BIT_SUB_TERR_DATA]
        |=> (out_sample_out.terr_im == $past(q_data.terr_im)))
        else $error("terrestrial data altered while not selected");

    chk_weight_sub: assert property ( // [R11]
        s_take and q.sub_sel[`BIT_SUB_SAT_TWO_WEIGHT]
        |=> (out_sample_out.w2 == $past(q.w2)))
        else $error("sat two weight test value not used");

    chk_sample_hold: assert property ( // [R12]
        (out_valid_out && !out_ready_in) |=> out_valid_out && $stable(out_sample_out))
        else $error("output sample changed while stalled");

endmodule

// >>> rtl/sat_weight_prc_map.svh
// Purpose: register offsets, field positions, reset values and limits
// Assumes: byte-wide registers at 10-bit addresses
// Notes: included by the package; the register bank uses its macros without including it
`ifndef SAT_WEIGHT_PRC_MAP_SVH
`define SAT_WEIGHT_PRC_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define OFS_WEIGHT_GEN_ENABLE  10'h240
`define OFS_WEIGHT_GEN_STATE   10'h241
`define OFS_PRIME_CTRL         10'h250
`define OFS_PRIME_NUM_LOW      10'h251
`define OFS_PRIME_NUM_HIGH     10'h252
`define OFS_SUB_SELECT         10'h260
`define OFS_TERR_TEST_REAL     10'h261
`define OFS_TERR_TEST_IMAG     10'h262
`define OFS_SAT_ONE_TEST_REAL  10'h263
`define OFS_SAT_ONE_TEST_IMAG  10'h264
`define OFS_SAT_TWO_TEST_REAL  10'h265
`define OFS_SAT_TWO_TEST_IMAG  10'h266
`define OFS_SAT_ONE_WEIGHT     10'h267
`define OFS_SAT_TWO_WEIGHT     10'h268

////////////////////////////////////////////////////////////////////////////////
// reset values
`define RST_WEIGHT_GEN_ENABLE  8'hFF
`define RST_ZERO_BYTE          8'h00

////////////////////////////////////////////////////////////////////////////////
// weight generator enable fields
`define BIT_SAT_TWO_BAD_SYNC   7
`define BIT_SAT_TWO_SLIP       6
`define BIT_SAT_TWO_QUEUE      5
`define BIT_SAT_TWO_CALC       4
`define BIT_SAT_ONE_BAD_SYNC   3
`define BIT_SAT_ONE_SLIP       2
`define BIT_SAT_ONE_QUEUE      1
`define BIT_SAT_ONE_CALC       0

// prime channel control fields
`define BIT_PRIME_ENABLE       0
`define BIT_PRIME_SRC_HI       2
`define BIT_PRIME_SRC_LO       1
`define BIT_PRIME_NUM_TOP      8
`define CODE_SRC_SAT_ONE       2'h0
`define CODE_SRC_SAT_TWO       2'h1
`define CODE_SRC_TERR          2'h2
`define CODE_SRC_RESERVED      2'h3
`define PRIME_NUM_MIN          9'h001
`define PRIME_NUM_MAX          9'h102

// substitution select fields
`define BIT_SUB_SAT_TWO_WEIGHT 4
`define BIT_SUB_SAT_ONE_WEIGHT 3
`define BIT_SUB_SAT_TWO_DATA   2
`define BIT_SUB_SAT_ONE_DATA   1
`define BIT_SUB_TERR_DATA      0

`define ZERO_NIBBLE            4'h0
`define QUEUE_DEPTH_DEFAULT    8

`endif

// >>> rtl/sat_weight_prc_pkg.sv
// Purpose: shared types of the weight, prime channel and test register bank
// Assumes: map header defines every number
// Notes: sample_t carries one symbol of all streams
`include "sat_weight_prc_map.svh"

package sat_weight_prc_pkg;

    typedef enum logic [1:0] {
        SRC_SAT_ONE  = `CODE_SRC_SAT_ONE,
        SRC_SAT_TWO  = `CODE_SRC_SAT_TWO,
        SRC_TERR     = `CODE_SRC_TERR,
        SRC_RESERVED = `CODE_SRC_RESERVED
    } prime_source_t;

    typedef struct packed {
        logic [7:0] terr_re;
        logic [7:0] terr_im;
        logic [3:0] s1_re;
        logic [3:0] s1_im;
        logic [3:0] s2_re;
        logic [3:0] s2_im;
        logic [3:0] w1;
        logic [3:0] w2;
        logic       bad1;
        logic       slip1;
        logic       bad2;
        logic       slip2;
    } sample_t;

    typedef struct packed {
        logic [7:0]    gen_enable;
        logic [1:0]    gen_state;
        logic          prime_en;
        prime_source_t prime_src;
        logic [8:0]    prime_num;
        logic          prime_run;
        logic [4:0]    sub_sel;
        logic [7:0]    terr_re;
        logic [7:0]    terr_im;
        logic [3:0]    s1_re;
        logic [3:0]    s1_im;
        logic [3:0]    s2_re;
        logic [3:0]    s2_im;
        logic [3:0]    w1;
        logic [3:0]    w2;
        logic [7:0]    rdata;
        logic          rvalid;
        sample_t       out;
        logic          out_valid;
    } bank_state_t;

endpackage

// >>> rtl/sample_queue.sv
// Purpose: sample FIFO with registered read data
// Assumes: reset already synchronised by the caller
// Notes: holds DEPTH words in memory plus one in the output register
`timescale 1ns/1ps

module sample_queue #(
    parameter int unsigned WIDTH = 44,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr;
        logic [PW-1:0]               rd;
        logic [CW-1:0]               cnt;
        logic [WIDTH-1:0]            out_data;
        logic                        out_valid;
        logic                        in_ready;
    } queue_state_t;

    queue_state_t q;
    queue_state_t n;
    logic         push;
    logic         pop;
    logic         load;

    function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
        step = (p == LAST) ? '0 : p + PW'(1);
    endfunction

    always_comb begin
        n    = q;
        push = in_valid_in && q.in_ready;
        pop  = q.out_valid && out_ready_in;
        load = (q.cnt != '0) && (!q.out_valid || pop);
        if (push) begin
            n.mem[q.wr] = in_data_in;
            n.wr        = step(q.wr);
        end
        if (load) begin
            n.out_data  = q.mem[q.rd];
            n.rd        = step(q.rd);
            n.out_valid = 1'b1;
        end else if (pop) begin
            n.out_valid = 1'b0;
        end
        n.cnt      = q.cnt + CW'(push) - CW'(load);
        n.in_ready = (n.cnt != FULL);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign in_ready_out  = q.in_ready;
    assign out_valid_out = q.out_valid;
    assign out_data_out  = q.out_data;

endmodule

// >>> tb/datapath_model.sv
// Purpose: far-side datapath model that offers and takes symbols
// Assumes: mode 0 always takes, 1 takes at random, 2 never takes
// Notes: an offer is held until taken; idle data changes every cycle
`timescale 1ns/1ps
module datapath_model
    import sat_weight_prc_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       send_in,
    input  wire logic [1:0] mode_in,
    input  wire logic       ready_in,
    output logic            valid_out,
    output sample_t         sample_out,
    output logic            take_out
);
////////////////////////////////////////
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            valid_out  <= 1'b0;
            sample_out <= '0;
            take_out   <= 1'b0;
        end else begin
            if (!valid_out || ready_in) begin
                valid_out  <= send_in && ($urandom_range(3) != 0);
                sample_out <= sample_t'(44'({$urandom, $urandom}));
            end
            take_out <= (mode_in == 2'h0) || (mode_in == 2'h1 && $urandom_range(2) == 0);
        end
    end
endmodule

// >>> tb/tb.sv
// Purpose: self-checking bench of the weight, prime channel and test registers
// Assumes: queue depth 8
// Notes: controls change only while no symbol is in flight
`timescale 1ns/1ps
module tb
    import sat_weight_prc_pkg::*;
;
    logic       clk_in = 1'b0;
    logic       rst_n_in = 1'b0;
    logic       wr_en = 1'b0;
    logic       rd_en = 1'b0;
    logic [9:0] addr = 10'h000;
    logic [7:0] wdata = 8'h00;
    logic       run1 = 1'b0;
    logic       run2 = 1'b0;
    logic       send = 1'b0;
    logic [1:0] mode = 2'h0;
    logic       s_vld, s_rdy, o_vld, o_rdy, r_vld, q1, k1, q2, k2, p_run;
    logic [1:0] p_src;
    logic [8:0] p_num;
    logic [7:0] r_data;
    sample_t    s_data, o_data;
    logic [7:0] shadow [64];
    sample_t    pend [$];
    int         err_count = 0;
    int         comparisons = 0;
    logic [9:0] regs [14] = '{10'h240, 10'h241, 10'h250, 10'h251, 10'h252, 10'h260, 10'h261,
                              10'h262, 10'h263, 10'h264, 10'h265, 10'h266, 10'h267, 10'h268};
    logic [8:0] nums [5] = '{9'h000, 9'h001, 9'h102, 9'h103, 9'h0A7};
////////////////////////////////////////
    always #12.5 clk_in = ~clk_in;

    sat_weight_prc_test_regs #(.QUEUE_DEPTH(8)) dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_wr_in(wr_en), .reg_rd_in(rd_en),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(r_data),
        .reg_rvalid_out(r_vld), .sample_valid_in(s_vld), .sample_in(s_data),
        .sample_ready_out(s_rdy), .out_valid_out(o_vld), .out_sample_out(o_data),
        .out_ready_in(o_rdy), .sat_one_weight_running_in(run1),
        .sat_two_weight_running_in(run2), .sat_one_weight_queue_on_out(q1),
        .sat_one_weight_calc_on_out(k1), .sat_two_weight_queue_on_out(q2),
        .sat_two_weight_calc_on_out(k2), .prime_run_out(p_run),
        .prime_source_out(p_src), .prime_number_out(p_num));

    datapath_model far (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .send_in(send), .mode_in(mode),
        .ready_in(s_rdy), .valid_out(s_vld), .sample_out(s_data), .take_out(o_rdy));
////////////////////////////////////////
    task automatic wrap_up();
        if (err_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [43:0] seen, input logic [43:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [7:0] mask_of(input logic [9:0] a);
        return (a == 10'h250) ? 8'h07 : (a == 10'h252) ? 8'h01 : (a == 10'h260) ? 8'h1F :
               (a > 10'h262) ? 8'h0F : 8'hFF;
    endfunction

    function automatic sample_t expect_out(input sample_t s);
        sample_t    e;
        logic [7:0] g;
        logic [7:0] u;
        e = s;
        g = shadow[6'h00];
        u = shadow[6'h20];
        e.terr_re = u[0] ? shadow[6'h21] : s.terr_re;
        e.terr_im = u[0] ? shadow[6'h22] : s.terr_im;
        e.s1_re = u[1] ? shadow[6'h23][3:0] : s.s1_re;
        e.s1_im = u[1] ? shadow[6'h24][3:0] : s.s1_im;
        e.s2_re = u[2] ? shadow[6'h25][3:0] : s.s2_re;
        e.s2_im = u[2] ? shadow[6'h26][3:0] : s.s2_im;
        e.w1 = u[3] ? shadow[6'h27][3:0] : ((s.bad1 && g[3]) || (s.slip1 && g[2])) ? 4'h0 : s.w1;
        e.w2 = u[4] ? shadow[6'h28][3:0] : ((s.bad2 && g[7]) || (s.slip2 && g[6])) ? 4'h0 : s.w2;
        return e;
    endfunction

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        shadow[a[5:0]] = d;
        @(posedge clk_in);
        wr_en <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        int n;
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_in);
        rd_en <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (r_vld !== 1'b1 && n < 4);
        check("read latency", 44'(n), 44'd1);
        if (n >= 4) wrap_up();
        d = r_data;
        @(posedge clk_in);
    endtask

    always @(posedge clk_in) begin
        if (s_vld === 1'b1 && s_rdy === 1'b1) pend.push_back(s_data);
        if (o_vld === 1'b1 && o_rdy === 1'b1) begin
            if (pend.size() == 0) check("stray output", 44'h1, 44'h0);
            else check("out sample", o_data, expect_out(pend.pop_front()));
        end
    end
////////////////////////////////////////
    initial begin
        int n;
        logic [1:0] src;
        logic [7:0] v;
        logic [7:0] r;
        void'($urandom(32'hC20F));
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        foreach (regs[i]) begin
            rd(regs[i], v);
            check("reset value", v, (regs[i] == 10'h240) ? 8'hFF : 8'h00);
        end
        check("gates after reset", {k1, q1, k2, q2}, 4'hF);
        wr(10'h2FF, 8'hA5);
        rd(10'h2FF, v);
        check("unmapped read", v, 8'h00);
        wr(10'h241, 8'hFF);
        rd(10'h241, v);
        check("read-only state", v, 8'h00);
        foreach (regs[i]) begin
            if (regs[i] != 10'h241 && regs[i] != 10'h250) begin
                r = 8'($urandom);
                wr(regs[i], r);
                rd(regs[i], v);
                check("read back", v, r & mask_of(regs[i]));
            end
        end
        repeat (4) begin
            r = 8'($urandom);
            wr(10'h240, r);
            check("gate outputs", {q2, k2, q1, k1}, {r[5], r[4], r[1], r[0]});
        end
        for (int i = 0; i < 4; i++) begin
            run1 <= i[0];
            run2 <= i[1];
            repeat (3) @(posedge clk_in);
            rd(10'h241, v);
            check("running state", v, {6'h00, i[1], i[0]});
        end
        src = 2'h0;
        for (int c = 0; c < 8; c++) begin
            wr(10'h250, 8'(c));
            if (c[2:1] != 2'h3) src = c[2:1];
            rd(10'h250, v);
            check("prime control", v, {5'h00, src, c[0]});
            foreach (nums[k]) begin
                wr(10'h251, nums[k][7:0]);
                wr(10'h252, {7'h00, nums[k][8]});
                @(negedge clk_in);
                check("prime number", p_num, nums[k]);
                check("prime source", p_src, src);
                check("prime run", p_run, c[0] && nums[k] != 9'h000 && nums[k] < 9'h103);
                @(posedge clk_in);
            end
        end
        for (int t = 0; t < 6; t++) begin
            wr(10'h240, 8'($urandom));
            for (int a = 10'h260; a <= 10'h268; a++) wr(10'(a), 8'($urandom));
            if (t == 1) wr(10'h260, 8'h00);
            if (t == 2) wr(10'h260, 8'h1F);
            send <= 1'b1;
            mode <= (t == 0) ? 2'h2 : 2'h1;
            if (t == 0) begin
                n = 0;
                while (s_rdy !== 1'b0 && n < 100) begin
                    @(negedge clk_in);
                    n++;
                end
                // eight in memory, one in the queue output, one in the output stage
                check("queue holds", 44'(pend.size()), 44'd10);
                if (n >= 100) wrap_up();
                @(posedge clk_in);
                mode <= 2'h1;
            end
            repeat (60) @(posedge clk_in);
            send <= 1'b0;
            n = 0;
            while ((pend.size() != 0 || o_vld !== 1'b0 || s_vld !== 1'b0) && n < 500) begin
                @(negedge clk_in);
                n++;
            end
            check("drain time", 44'(n >= 500), 44'h0);
            if (n >= 500) wrap_up();
            @(posedge clk_in);
        end
        // second reset after register traffic, once the streams have drained and send is low
        rst_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        check("idle in reset", {o_vld, s_rdy, r_vld}, 3'h0);
        rst_n_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        check("gates after second reset", {k1, q1, k2, q2}, 4'hF);
        rd(10'h240, v);
        check("enable after second reset", v, 8'hFF);
        rd(10'h260, v);
        check("select after second reset", v, 8'h00);
        wrap_up();
    end
endmodule
